/* hdl/bsc_pkg.sv */
// Shared types and constants for the boundary-scan test port
`default_nettype none
package bsc_pkg;

  // Instruction codes
  localparam logic [3:0] IR_BYPASS = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h1;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_USER   = 4'h3;
  localparam logic [3:0] IR_CLAMP  = 4'h4;
  localparam logic [3:0] IR_HIGHZ  = 4'h5;
  localparam logic [3:0] IR_EXTEST = 4'h7;
  localparam logic [3:0] IR_IFACE  = 4'h8;
  localparam logic [3:0] IR_REG_RD = 4'h9;
  localparam logic [3:0] IR_REG_WR = 4'ha;
  localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;

  // Last bit index of each data chain
  localparam logic [4:0] LAST_ONE = 5'h00;
  localparam logic [4:0] LAST_BSR = 5'h17;
  localparam logic [4:0] LAST_WORD = 5'h1f;
  localparam logic [4:0] LAST_REG = 5'h0e;

  // Identification fields, values arbitrary
  localparam logic [3:0]  ID_VERSION = 4'h6;
  localparam logic [15:0] ID_PART    = 16'h1234;
  localparam logic [10:0] ID_MAKER   = 11'h155;
  localparam logic [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // Boundary cell number of each bidirectional pad's data cell, then of the aux output cell and the line 3 input cell
  localparam int NPAD = 11;
  localparam logic [10:0][4:0] DATA_CELL = {5'h16, 5'h14, 5'h12, 5'h10, 5'h0e,
    5'h0c, 5'h0a, 5'h08, 5'h04, 5'h02, 5'h00};
  localparam logic [4:0] AUX_CELL = 5'h07;
  localparam logic [4:0] LINE3_CELL = 5'h06;

  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
    UP_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
    EX1_IR = 4'hc, PA_IR = 4'hd, EX2_IR = 4'he, UP_IR = 4'hf
  } bsc_tap_t;

  typedef struct packed {
    logic [10:0] o;
    logic [10:0] oe;
    logic        aux_o;
  } bsc_pad_t;

  typedef struct packed {
    logic [10:0] i;
    logic        line3_i;
  } bsc_pin_in_t;

  typedef struct packed {
    bsc_tap_t    state;
    logic [3:0]  ir_sr;
    logic [3:0]  ir;
    logic [31:0] dr_sr;
    logic [23:0] upd;
    logic [23:0] cap_s1;
    logic [23:0] cap_s2;
    logic [31:0] user_s1;
    logic [31:0] user_s2;
    logic        iface_off;
    logic [6:0]  addr;
    logic [7:0]  wdata;
    logic        req_tgl;
    logic        req_wr;
    logic        ack_s1;
    logic        ack_s2;
  } bsc_tck_st_t;

  typedef struct packed {
    logic       req_s1;
    logic       req_s2;
    logic       req_s3;
    logic       off_s1;
    logic       off_s2;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       ack_tgl;
  } bsc_sys_st_t;

endpackage

`default_nettype wire

/* hdl/bsc_tap.sv */
// Boundary-scan test access port with register access commands
`timescale 1ns/1ps
`default_nettype none

module bsc_tap (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire logic                 tck,
  input  wire logic                 tms_i,
  input  wire logic                 tdi_i,
  output logic                      tdo_o,
  output logic                      tdo_oe,
  output logic [2:0]                pullup_en,
  input  wire bsc_pkg::bsc_pad_t    core_pad,
  output bsc_pkg::bsc_pad_t         pad,
  input  wire bsc_pkg::bsc_pin_in_t pin_in,
  input  wire logic [31:0]          user_code_i,
  output logic                      host_iface_disable,
  output logic [6:0]                reg_addr,
  output logic [7:0]                reg_wdata,
  output logic                      reg_wr,
  output logic                      reg_rd,
  input  wire logic [7:0]           reg_rdata_i
);

  bsc_pkg::bsc_tck_st_t t_q;
  bsc_pkg::bsc_tck_st_t t_d;
  bsc_pkg::bsc_sys_st_t s_q;
  bsc_pkg::bsc_sys_st_t s_d;
  logic                 tdo_q;
  logic                 oe_q;
  logic [23:0]          cap;
  logic                 ext_drive;
  logic                 hiz;
  logic [4:0]           last;
  logic [31:0]          shifted;
  logic [7:0]           rd_val;

  // Pads are pulled up; tied on for the pad ring
  assign pullup_en = 3'h7;

  assign ext_drive = (t_q.ir == bsc_pkg::IR_EXTEST) || (t_q.ir == bsc_pkg::IR_CLAMP);
  assign hiz       = (t_q.ir == bsc_pkg::IR_HIGHZ);

  // Pad multiplexing and capture values per bidirectional pad
  generate
    for (genvar k = 0; k < bsc_pkg::NPAD; k++)
    begin : g_pad
      localparam logic [4:0] DC = bsc_pkg::DATA_CELL[k];
      assign cap[DC]        = pin_in.i[k];
      assign cap[DC + 5'h1] = core_pad.oe[k];
      assign pad.o[k]  = ext_drive ? t_q.upd[DC] : core_pad.o[k];
      assign pad.oe[k] = hiz ? 1'b0 : (ext_drive ? t_q.upd[DC + 5'h1] : core_pad.oe[k]);
    end
  endgenerate

  assign cap[bsc_pkg::AUX_CELL]   = core_pad.aux_o;
  assign cap[bsc_pkg::LINE3_CELL] = pin_in.line3_i;
  assign pad.aux_o = ext_drive ? t_q.upd[bsc_pkg::AUX_CELL] : core_pad.aux_o;

  // Read data is valid once the system side has answered
  assign rd_val = (t_q.ack_s2 == t_q.req_tgl) ? s_q.rdata : 8'h00;

  // Chain length by instruction
  always_comb
  begin
    unique case (t_q.ir)
      bsc_pkg::IR_SAMPLE,
      bsc_pkg::IR_EXTEST: last = bsc_pkg::LAST_BSR;
      bsc_pkg::IR_IDCODE,
      bsc_pkg::IR_USER:   last = bsc_pkg::LAST_WORD;
      bsc_pkg::IR_REG_RD,
      bsc_pkg::IR_REG_WR: last = bsc_pkg::LAST_REG;
      default:            last = bsc_pkg::LAST_ONE;
    endcase
  end

  always_comb
  begin
    shifted       = t_q.dr_sr >> 1;
    shifted[last] = tdi_i;
  end

  // Test clock domain: controller, chains, command effects
  always_comb
  begin
    t_d = t_q;
    t_d.cap_s1  = cap;
    t_d.cap_s2  = t_q.cap_s1;
    t_d.user_s1 = user_code_i;
    t_d.user_s2 = t_q.user_s1;
    t_d.ack_s1  = s_q.ack_tgl;
    t_d.ack_s2  = t_q.ack_s1;
    unique case (t_q.state)
      bsc_pkg::TLR:    t_d.state = tms_i ? bsc_pkg::TLR : bsc_pkg::RTI;
      bsc_pkg::RTI:    t_d.state = tms_i ? bsc_pkg::SEL_DR : bsc_pkg::RTI;
      bsc_pkg::SEL_DR: t_d.state = tms_i ? bsc_pkg::SEL_IR : bsc_pkg::CAP_DR;
      bsc_pkg::CAP_DR: t_d.state = tms_i ? bsc_pkg::EX1_DR : bsc_pkg::SH_DR;
      bsc_pkg::SH_DR:  t_d.state = tms_i ? bsc_pkg::EX1_DR : bsc_pkg::SH_DR;
      bsc_pkg::EX1_DR: t_d.state = tms_i ? bsc_pkg::UP_DR : bsc_pkg::PA_DR;
      bsc_pkg::PA_DR:  t_d.state = tms_i ? bsc_pkg::EX2_DR : bsc_pkg::PA_DR;
      bsc_pkg::EX2_DR: t_d.state = tms_i ? bsc_pkg::UP_DR : bsc_pkg::SH_DR;
      bsc_pkg::UP_DR:  t_d.state = tms_i ? bsc_pkg::SEL_DR : bsc_pkg::RTI;
      bsc_pkg::SEL_IR: t_d.state = tms_i ? bsc_pkg::TLR : bsc_pkg::CAP_IR;
      bsc_pkg::CAP_IR: t_d.state = tms_i ? bsc_pkg::EX1_IR : bsc_pkg::SH_IR;
      bsc_pkg::SH_IR:  t_d.state = tms_i ? bsc_pkg::EX1_IR : bsc_pkg::SH_IR;
      bsc_pkg::EX1_IR: t_d.state = tms_i ? bsc_pkg::UP_IR : bsc_pkg::PA_IR;
      bsc_pkg::PA_IR:  t_d.state = tms_i ? bsc_pkg::EX2_IR : bsc_pkg::PA_IR;
      bsc_pkg::EX2_IR: t_d.state = tms_i ? bsc_pkg::UP_IR : bsc_pkg::SH_IR;
      bsc_pkg::UP_IR:  t_d.state = tms_i ? bsc_pkg::SEL_DR : bsc_pkg::RTI;
    endcase
    unique case (t_q.state)
      bsc_pkg::CAP_IR: t_d.ir_sr = bsc_pkg::IR_CAPTURE_VAL;
      bsc_pkg::SH_IR:  t_d.ir_sr = {tdi_i, t_q.ir_sr[3:1]};
      bsc_pkg::UP_IR:  t_d.ir = t_q.ir_sr;
      bsc_pkg::SH_DR:  t_d.dr_sr = shifted;
      bsc_pkg::CAP_DR:
      begin
        unique case (t_q.ir)
          bsc_pkg::IR_SAMPLE,
          bsc_pkg::IR_EXTEST: t_d.dr_sr = {8'h00, t_q.cap_s2};
          bsc_pkg::IR_IDCODE: t_d.dr_sr = bsc_pkg::ID_WORD;
          bsc_pkg::IR_USER:   t_d.dr_sr = t_q.user_s2;
          bsc_pkg::IR_IFACE:  t_d.dr_sr = {31'h0, t_q.iface_off};
          bsc_pkg::IR_REG_RD: t_d.dr_sr = {17'h0, rd_val, t_q.addr};
          bsc_pkg::IR_REG_WR: t_d.dr_sr = {17'h0, t_q.wdata, t_q.addr};
          default:            t_d.dr_sr = 32'h0;
        endcase
      end
      bsc_pkg::UP_DR:
      begin
        unique case (t_q.ir)
          bsc_pkg::IR_SAMPLE,
          bsc_pkg::IR_EXTEST: t_d.upd = t_q.dr_sr[23:0];
          bsc_pkg::IR_IFACE:  t_d.iface_off = t_q.dr_sr[0];
          bsc_pkg::IR_REG_RD:
          begin
            if (t_q.iface_off)
            begin
              t_d.addr    = t_q.dr_sr[14:8];
              t_d.req_wr  = 1'b0;
              t_d.req_tgl = ~t_q.req_tgl;
            end
          end
          bsc_pkg::IR_REG_WR:
          begin
            if (t_q.iface_off)
            begin
              t_d.addr    = t_q.dr_sr[6:0];
              t_d.wdata   = t_q.dr_sr[14:7];
              t_d.req_wr  = 1'b1;
              t_d.req_tgl = ~t_q.req_tgl;
            end
          end
          default: t_d.upd = t_q.upd;
        endcase
      end
      default: t_d.ir_sr = t_q.ir_sr;
    endcase
    if (t_d.state == bsc_pkg::TLR)
    begin
      t_d.ir = bsc_pkg::IR_IDCODE;
    end
  end

  // All test state advances only on TCK edges
  always_ff @(posedge tck or negedge reset_n)
  begin
    if (!reset_n)
    begin
      t_q       <= '0;
      t_q.state <= bsc_pkg::TLR;
      t_q.ir    <= bsc_pkg::IR_IDCODE;
    end
    else
    begin
      t_q <= t_d;
    end
  end

  // Serial output launched on the falling edge
  always_ff @(negedge tck or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tdo_q <= 1'b0;
      oe_q  <= 1'b0;
    end
    else
    begin
      tdo_q <= (t_q.state == bsc_pkg::SH_IR) ? t_q.ir_sr[0] : t_q.dr_sr[0];
      oe_q  <= (t_q.state == bsc_pkg::SH_IR) || (t_q.state == bsc_pkg::SH_DR);
    end
  end

  assign tdo_o  = tdo_q;
  assign tdo_oe = oe_q;

  // System clock side: request crossing and register strobes
  always_comb
  begin
    s_d = s_q;
    s_d.req_s1 = t_q.req_tgl;
    s_d.req_s2 = s_q.req_s1;
    s_d.req_s3 = s_q.req_s2;
    s_d.off_s1 = t_q.iface_off;
    s_d.off_s2 = s_q.off_s1;
    s_d.wr = 1'b0;
    s_d.rd = 1'b0;
    if (s_q.rd)
    begin
      s_d.rdata   = reg_rdata_i;
      s_d.ack_tgl = ~s_q.ack_tgl;
    end
    if (s_q.req_s2 != s_q.req_s3)
    begin
      s_d.addr = t_q.addr;
      if (t_q.req_wr)
      begin
        s_d.wdata   = t_q.wdata;
        s_d.wr      = 1'b1;
        s_d.ack_tgl = ~s_q.ack_tgl;
      end
      else
      begin
        s_d.rd = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign host_iface_disable = s_q.off_s2;
  assign reg_addr  = s_q.addr;
  assign reg_wdata = s_q.wdata;
  assign reg_wr    = s_q.wr;
  assign reg_rd    = s_q.rd;

  AST_TLR_FIVE: assert property (@(posedge tck) disable iff (!reset_n)
    tms_i [*5] |=> (t_q.state == bsc_pkg::TLR))
    else $error("Five TMS highs did not reach reset state");

  AST_TLR_IR: assert property (@(posedge tck) disable iff (!reset_n)
    (t_q.state == bsc_pkg::TLR) |-> (t_q.ir == bsc_pkg::IR_IDCODE))
    else $error("Reset state without identification instruction");

  AST_RTI_SEL: assert property (@(posedge tck) disable iff (!reset_n)
    (t_q.state == bsc_pkg::RTI) && tms_i |=> (t_q.state == bsc_pkg::SEL_DR))
    else $error("TMS high in idle did not select data scan");

  AST_CAP_IR: assert property (@(posedge tck) disable iff (!reset_n)
    (t_q.state == bsc_pkg::CAP_IR) |=> (t_q.ir_sr == 4'h1))
    else $error("Instruction capture pattern wrong");

  AST_TDO_IDLE: assert property (@(posedge tck) disable iff (!reset_n)
    $past(t_q.state) != bsc_pkg::SH_DR && $past(t_q.state) != bsc_pkg::SH_IR
    && (t_q.state != bsc_pkg::SH_DR) && (t_q.state != bsc_pkg::SH_IR) |-> !tdo_oe)
    else $error("TDO driven outside shifting");

  AST_BYPASS: assert property (@(posedge tck) disable iff (!reset_n)
    (t_q.state == bsc_pkg::SH_DR) && (t_q.ir == bsc_pkg::IR_BYPASS)
    |=> (t_q.dr_sr[0] == $past(tdi_i)))
    else $error("Bypass bit does not follow TDI");

  AST_UNASSIGNED: assert property (@(posedge tck) disable iff (!reset_n)
    (t_q.state == bsc_pkg::CAP_DR) && (t_q.ir == 4'h6) |=> (t_q.dr_sr == 32'h0))
    else $error("Unassigned code does not act as bypass");

  AST_ID_CAP: assert property (@(posedge tck) disable iff (!reset_n)
    (t_q.state == bsc_pkg::CAP_DR) && (t_q.ir == bsc_pkg::IR_IDCODE)
    |=> (t_q.dr_sr[0] == 1'b1) && (t_q.dr_sr == bsc_pkg::ID_WORD))
    else $error("Identification word not captured");

  AST_IFACE: assert property (@(posedge tck) disable iff (!reset_n)
    (t_q.state == bsc_pkg::UP_DR) && (t_q.ir == bsc_pkg::IR_IFACE)
    |=> (t_q.iface_off == $past(t_q.dr_sr[0])))
    else $error("Interface switch not applied at update");

  AST_WR_REQ: assert property (@(posedge tck) disable iff (!reset_n)
    (t_q.state == bsc_pkg::UP_DR) && (t_q.ir == bsc_pkg::IR_REG_WR) && t_q.iface_off
    |=> $changed(t_q.req_tgl) && t_q.req_wr && (t_q.wdata == $past(t_q.dr_sr[14:7])))
    else $error("Register write not requested");

  AST_RD_ACK: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rd |=> !reg_rd && $changed(s_q.ack_tgl) && (s_q.rdata == $past(reg_rdata_i)))
    else $error("Read data not taken after strobe");

  AST_TDO_SHIFT: assert property (@(posedge tck) disable iff (!reset_n)
    (t_q.state == bsc_pkg::SH_DR) |-> tdo_oe && (tdo_o == t_q.dr_sr[0]))
    else $error("TDO not driven with chain bit while shifting");

  AST_IR_UPDATE: assert property (@(posedge tck) disable iff (!reset_n)
    (t_q.state == bsc_pkg::UP_IR) |=> (t_q.ir == $past(t_q.ir_sr)))
    else $error("Instruction not applied at update");

  AST_LEN_BSR: assert property (@(posedge tck) disable iff (!reset_n)
    (t_q.state == bsc_pkg::SH_DR) && (t_q.ir == bsc_pkg::IR_EXTEST)
    |=> (t_q.dr_sr[23] == $past(tdi_i)))
    else $error("Boundary chain not 24 cells long");

  AST_HIGHZ: assert property (@(posedge tck) disable iff (!reset_n)
    (t_q.ir == bsc_pkg::IR_HIGHZ) |-> (pad.oe == 11'h000))
    else $error("Pad enable active under high impedance");

  AST_HOST_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_wr || reg_rd) |-> host_iface_disable)
    else $error("Register strobe while host interfaces live");

endmodule // bsc_tap

`default_nettype wire

/* tb/bsc_tester.sv */
// Test controller model driving the scan port from outside
`timescale 1ns/1ps
`default_nettype none
module bsc_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic q;
  logic qe;
  logic oe_ok;

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One test clock period, lines change only after the fall
  task automatic tick(input logic m, input logic d);
    tms = m;
    tdi = d;
    #40 tck = 1'b1;
    q = tdo;
    qe = tdo_oe;
    #40 tck = 1'b0;
  endtask

  // Released lines float to the pull-up level, clock stands still
  task automatic idle();
    tms = 1'b1;
    tdi = 1'b1;
  endtask

  task automatic tlr();
    repeat (5) tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    idle();
  endtask

  // From Run-Test-Idle through one scan of n bits, LSB first
  task automatic shift(input logic ir, input int n, input logic [31:0] d,
                       output logic [31:0] o);
    o = '0;
    oe_ok = 1'b1;
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b1);
    tick(1'b1, 1'b1);
    if (ir)
      tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, d[i]);
      o[i] = q;
      oe_ok &= qe;
    end
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    idle();
  endtask
endmodule // bsc_tester
`default_nettype wire

/* tb/test_boundary_scan_tap.sv */
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module test_boundary_scan_tap;
  logic                 clk_sys;
  logic                 reset_n;
  wire logic            tck;
  wire logic            tms;
  wire logic            tdi;
  logic                 tdo_o;
  logic                 tdo_oe;
  logic [2:0]           pullup_en;
  bsc_pkg::bsc_pad_t    core_pad;
  bsc_pkg::bsc_pad_t    pad;
  bsc_pkg::bsc_pin_in_t pin_in;
  logic [31:0]          user_code_i;
  logic                 host_iface_disable;
  logic [6:0]           reg_addr;
  logic [7:0]           reg_wdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [7:0]           reg_rdata_i;
  logic [31:0]          exp_q[$];
  logic [31:0]          seen_v;
  logic [31:0]          o_v;
  logic [31:0]          d;
  logic [6:0]           a;
  logic [7:0]           w;
  int                   errors;
  int                   cmp_count;
  int                   cyc;
  integer               seed;
  event                 seen_ev;
  bit                   frz;
  logic [3:0]           byp_codes [9] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'hb, 4'hc,
                                          4'hd, 4'he, 4'hf};

  bsc_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_o), .tdo_oe(tdo_oe));

  bsc_tap i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .tck(tck), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .pullup_en(pullup_en),
    .core_pad(core_pad), .pad(pad), .pin_in(pin_in), .user_code_i(user_code_i),
    .host_iface_disable(host_iface_disable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_i(reg_rdata_i));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Random pin levels, frozen while a capture is compared
  always @(negedge clk_sys)
    if (!frz)
    begin
      core_pad <= 23'($random(seed));
      pin_in   <= 12'($random(seed));
    end

  task automatic report_and_stop();
    // A result that never appeared is a mismatch too
    if (exp_q.size() != 0)
      errors++;
    $display("Comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic note(input logic [31:0] e);
    exp_q.push_back(e);
  endtask

  // Any result other than all ones with no note waiting counts as a mismatch
  task automatic take(input logic [31:0] s);
    if (exp_q.size() == 0)
      check(s, 32'hffff_ffff);
    else
      check(s, exp_q.pop_front());
  endtask

  task automatic obs(input logic [31:0] s);
    seen_v = s;
    -> seen_ev;
    #1;
  endtask

  always @(seen_ev)
    take(seen_v);

  always @(negedge clk_sys)
    if (reg_wr === 1'b1 || reg_rd === 1'b1)
      take({16'h0, reg_rd, reg_addr, reg_rd ? 8'h00 : reg_wdata});

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end

  function automatic bsc_pkg::bsc_pad_t pad_of(input logic [23:0] v);
    bsc_pkg::bsc_pad_t p;
    for (int k = 0; k < bsc_pkg::NPAD; k++)
    begin
      p.o[k]  = v[bsc_pkg::DATA_CELL[k]];
      p.oe[k] = v[bsc_pkg::DATA_CELL[k] + 5'h01];
    end
    p.aux_o = v[bsc_pkg::AUX_CELL];
    return p;
  endfunction

  // Expected boundary capture from the present pin levels
  function automatic logic [23:0] cap_of();
    logic [23:0] c;
    c = '0;
    for (int k = 0; k < bsc_pkg::NPAD; k++)
    begin
      c[bsc_pkg::DATA_CELL[k]]         = pin_in.i[k];
      c[bsc_pkg::DATA_CELL[k] + 5'h01] = core_pad.oe[k];
    end
    c[bsc_pkg::AUX_CELL]   = core_pad.aux_o;
    c[bsc_pkg::LINE3_CELL] = pin_in.line3_i;
    return c;
  endfunction

  task automatic ir(input logic [3:0] c);
    note(32'(bsc_pkg::IR_CAPTURE_VAL));
    i_tester.shift(1'b1, 4, {28'h0, c}, o_v);
    obs(o_v);
  endtask

  task automatic dr(input logic [31:0] v, input int n, input bit chk);
    i_tester.shift(1'b0, n, v, o_v);
    if (chk)
      obs(o_v);
    check(32'(i_tester.oe_ok), 32'h1);
    check(32'(tdo_oe), 32'h0);
  endtask

  initial
  begin
    seed = 32'h1ca1;
    reset_n = 1'b0;
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    user_code_i = $random(seed);
    reg_rdata_i = 8'h00;
    fork
      i_tester.tlr();
      begin
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
      end
    join
    note(32'h7);
    obs({29'h0, pullup_en});
    note(bsc_pkg::ID_WORD);
    dr(32'h0, 32, 1'b1);
    ir(bsc_pkg::IR_USER);
    note(user_code_i);
    dr(32'h0, 32, 1'b1);
    foreach (byp_codes[k])
    begin
      ir(byp_codes[k]);
      d = $random(seed);
      note({24'h0, d[6:0], 1'b0});
      dr(d, 8, 1'b1);
    end
    // Sample the frozen pins and preload the update cells
    frz = 1'b1;
    ir(bsc_pkg::IR_SAMPLE);
    d = $random(seed);
    note(32'(cap_of()));
    dr(d, 24, 1'b1);
    frz = 1'b0;
    ir(bsc_pkg::IR_EXTEST);
    note(32'(pad_of(d[23:0])));
    obs(32'(pad));
    d = $random(seed);
    note(32'(pad_of(d[23:0])));
    dr(d, 24, 1'b0);
    obs(32'(pad));
    ir(bsc_pkg::IR_CLAMP);
    note(32'(pad_of(d[23:0])));
    obs(32'(pad));
    ir(bsc_pkg::IR_HIGHZ);
    note(32'h0);
    obs(32'(pad.oe));
    // Write while host interfaces live must give no strobe
    ir(bsc_pkg::IR_REG_WR);
    dr(32'h1234, 15, 1'b0);
    repeat (20) @(negedge clk_sys);
    ir(bsc_pkg::IR_IFACE);
    dr(32'h1, 1, 1'b0);
    for (int i = 0; i < 20 && host_iface_disable !== 1'b1; i++)
      @(negedge clk_sys);
    note(32'h1);
    obs({31'h0, host_iface_disable});
    ir(bsc_pkg::IR_REG_WR);
    repeat (2)
    begin
      a = 7'($random(seed));
      w = 8'($random(seed));
      note({17'h0, a, w});
      dr({17'h0, w, a}, 15, 1'b0);
    end
    repeat (20) @(negedge clk_sys);
    reg_rdata_i = 8'($random(seed));
    a = 7'($random(seed));
    ir(bsc_pkg::IR_REG_RD);
    note({16'h0, 1'b1, a, 8'h00});
    dr({17'h0, a, 8'h00}, 15, 1'b0);
    repeat (20) @(negedge clk_sys);
    note({17'h0, reg_rdata_i, a});
    note({16'h0, 1'b1, a, 8'h00});
    dr({17'h0, a, 8'h00}, 15, 1'b1);
    repeat (20) @(negedge clk_sys);
    // Leave the controller in Shift-DR, then escape with TMS high
    ir(bsc_pkg::IR_BYPASS);
    i_tester.tick(1'b1, 1'b1);
    i_tester.tick(1'b0, 1'b1);
    i_tester.tick(1'b0, 1'b1);
    i_tester.tlr();
    note(bsc_pkg::ID_WORD);
    dr(32'h0, 32, 1'b1);
    report_and_stop();
  end
endmodule // test_boundary_scan_tap
`default_nettype wire
